// [design/core_regs.sv]
// core register group: pointers, indirect ports, status, bank, W, PC
// assumes an AHB-Lite master, registered data RAM and flash on the far side
`timescale 1ns/100ps
`default_nettype none
module core_regs
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // data memory
    output logic [12:0]      dmem_addr,
    output logic             dmem_rd,
    output logic             dmem_wr,
    output logic [7:0]       dmem_wdata,
    input  wire logic [7:0]  dmem_rdata,
    // program flash
    output logic [14:0]      flash_addr,
    output logic             flash_rd,
    input  wire logic [13:0] flash_rdata,
    // instruction datapath
    input  wire logic        alu_valid,
    input  wire logic [2:0]  alu_op,
    input  wire logic [7:0]  alu_operand,
    input  wire logic        alu_to_w,
    input  wire logic        alu_to_status,
    input  wire logic        pc_step,
    input  wire logic        watchdog_clear,
    input  wire logic        sleep_exec,
    input  wire logic        watchdog_fired,
    output logic [7:0]       alu_result,
    output logic [14:0]      pc_value,
    output logic [7:0]       w_value,
    output logic [7:0]       status_value,
    output logic [5:0]       bank_value,
    output logic [6:0]       program_counter_high_latch
);
    logic [15:0] ptr0, ptr1, next_ptr0, next_ptr1;
    logic [14:0] next_pc;
    logic [7:0]  next_w, next_status, next_alu_result;
    logic [5:0]  next_bank;
    logic [6:0]  next_pc_latch;
    core_regs_pkg::bus_state_e state, next_state;
    logic [3:0]  ap_idx, next_ap_idx;
    logic        ap_write, next_ap_write, tk_flash, next_tk_flash;
    logic        next_hreadyout;
    logic [31:0] next_hrdata;
    logic [12:0] next_dmem_addr;
    logic        next_dmem_rd, next_dmem_wr, next_flash_rd;
    logic [7:0]  next_dmem_wdata;
    logic [14:0] next_flash_addr;
    // decode of the transfer in its first data-phase cycle
    core_regs_pkg::target_e tgt;
    logic [3:0]  tgt_idx;
    logic [12:0] tgt_addr;
    logic [15:0] ptr_sel;
    logic [11:0] lin_off, lin_bank, lin_byte;
    logic        is_port, accept;

    function automatic logic [7:0] read_core(input logic [3:0] idx, input logic [14:0] pc,
        input logic [7:0] st, input logic [15:0] p0, input logic [15:0] p1,
        input logic [5:0] bk, input logic [7:0] w, input logic [6:0] lat);
        case (idx)
            core_regs_pkg::IDX_PC_LOW:  read_core = pc[7:0];
            core_regs_pkg::IDX_STATUS:  read_core = st;
            core_regs_pkg::IDX_PTR0_LO: read_core = p0[7:0];
            core_regs_pkg::IDX_PTR0_HI: read_core = p0[15:8];
            core_regs_pkg::IDX_PTR1_LO: read_core = p1[7:0];
            core_regs_pkg::IDX_PTR1_HI: read_core = p1[15:8];
            core_regs_pkg::IDX_BANK:    read_core = {2'h0, bk};
            core_regs_pkg::IDX_WORK:    read_core = w;
            core_regs_pkg::IDX_PC_LATCH: read_core = {1'b0, lat};
            default:                    read_core = 8'h00;
        endcase
    endfunction

    assign accept = hsel && hready && (htrans == core_regs_pkg::HTRANS_NONSEQ);
    assign is_port = (ap_idx == core_regs_pkg::IDX_PORT_ZERO)
                  || (ap_idx == core_regs_pkg::IDX_PORT_ONE);

    always_comb
    begin
        ptr_sel  = (ap_idx == core_regs_pkg::IDX_PORT_ONE) ? ptr1 : ptr0;
        lin_off  = ptr_sel[11:0];
        lin_bank = lin_off / core_regs_pkg::RAM_BLOCK_BYTES;
        lin_byte = lin_off % core_regs_pkg::RAM_BLOCK_BYTES;
        tgt      = core_regs_pkg::TGT_NONE;
        tgt_idx  = ap_idx;
        tgt_addr = 13'h0000;
        if (!is_port)
        begin
            if (ap_idx <= core_regs_pkg::IDX_PC_LATCH)
                tgt = core_regs_pkg::TGT_CORE;
        end
        else if (ptr_sel[core_regs_pkg::PTR_FLASH_BIT])
            tgt = core_regs_pkg::TGT_FLASH;
        else if (ptr_sel <= core_regs_pkg::BANKED_LAST)
        begin
            tgt_idx  = ptr_sel[3:0];
            tgt_addr = ptr_sel[12:0];
            if (ptr_sel[6:0] <= {3'h0, core_regs_pkg::IDX_PORT_ONE})
                tgt = core_regs_pkg::TGT_NONE;
            else if (ptr_sel[6:0] <= {3'h0, core_regs_pkg::IDX_PC_LATCH})
                tgt = core_regs_pkg::TGT_CORE;
            else
                tgt = core_regs_pkg::TGT_DATA;
        end
        else if (ptr_sel >= core_regs_pkg::LINEAR_BASE && ptr_sel <= core_regs_pkg::LINEAR_LAST)
        begin
            tgt_addr = {lin_bank[5:0], core_regs_pkg::RAM_BANK_START + lin_byte[6:0]};
            if (lin_bank < core_regs_pkg::LINEAR_BANKS)
                tgt = core_regs_pkg::TGT_DATA;
        end
    end

    logic        wr_core;
    logic [7:0]  wr_data, sub_b, res;
    logic [8:0]  sum;
    logic [4:0]  nib;
    always_comb
    begin
        next_state      = state;
        next_ap_idx     = ap_idx;
        next_ap_write   = ap_write;
        next_tk_flash   = tk_flash;
        next_hrdata     = hrdata;
        next_dmem_addr  = dmem_addr;
        next_dmem_wdata = dmem_wdata;
        next_dmem_rd    = 1'b0;
        next_dmem_wr    = 1'b0;
        next_flash_addr = flash_addr;
        next_flash_rd   = 1'b0;
        wr_core         = 1'b0;
        wr_data         = hwdata[7:0];
        case (state)
            core_regs_pkg::ST_IDLE, core_regs_pkg::ST_DONE:
            begin
                next_state = core_regs_pkg::ST_IDLE;
                if (accept)
                begin
                    next_state    = core_regs_pkg::ST_ACCESS;
                    next_ap_idx   = haddr[5:2];
                    next_ap_write = hwrite;
                end
            end
            core_regs_pkg::ST_ACCESS:
            begin
                next_state    = core_regs_pkg::ST_DONE;
                next_hrdata   = 32'h0000_0000;
                next_tk_flash = (tgt == core_regs_pkg::TGT_FLASH);
                case (tgt)
                    core_regs_pkg::TGT_CORE:
                    begin
                        wr_core = ap_write;
                        next_hrdata = {24'h000000, read_core(tgt_idx, pc_value, status_value,
                            ptr0, ptr1, bank_value, w_value, program_counter_high_latch)};
                    end
                    core_regs_pkg::TGT_DATA:
                    begin
                        next_state      = core_regs_pkg::ST_REQ;
                        next_dmem_addr  = tgt_addr;
                        next_dmem_wdata = hwdata[7:0];
                        next_dmem_rd    = !ap_write;
                        next_dmem_wr    = ap_write;
                    end
                    core_regs_pkg::TGT_FLASH:
                    begin
                        if (!ap_write)
                        begin
                            next_state      = core_regs_pkg::ST_REQ;
                            next_flash_addr = ptr_sel[14:0];
                            next_flash_rd   = 1'b1;
                        end
                    end
                    default:
                        next_state = core_regs_pkg::ST_DONE;
                endcase
            end
            core_regs_pkg::ST_REQ:
                next_state = tk_flash ? core_regs_pkg::ST_EXTRA : core_regs_pkg::ST_TAKE;
            core_regs_pkg::ST_EXTRA:
                next_state = core_regs_pkg::ST_TAKE;
            core_regs_pkg::ST_TAKE:
            begin
                next_state = core_regs_pkg::ST_DONE;
                if (tk_flash)
                    next_hrdata = {24'h000000, flash_rdata[7:0]};
                else if (!ap_write)
                    next_hrdata = {24'h000000, dmem_rdata};
            end
            default:
                next_state = core_regs_pkg::ST_IDLE;
        endcase
        // ready only where the master may finish the transfer
        next_hreadyout = (next_state == core_regs_pkg::ST_IDLE)
                      || (next_state == core_regs_pkg::ST_DONE);
    end

    always_comb
    begin
        next_ptr0       = ptr0;
        next_ptr1       = ptr1;
        next_bank       = bank_value;
        next_w          = w_value;
        next_pc_latch   = program_counter_high_latch;
        next_status     = status_value;
        next_alu_result = alu_result;
        next_pc         = pc_step ? pc_value + 15'h0001 : pc_value;
        if (wr_core)
        begin
            case (tgt_idx)
                core_regs_pkg::IDX_PC_LOW:
                    next_pc = {program_counter_high_latch, wr_data};
                core_regs_pkg::IDX_STATUS:  next_status[2:0] = wr_data[2:0];
                core_regs_pkg::IDX_PTR0_LO: next_ptr0[7:0]  = wr_data;
                core_regs_pkg::IDX_PTR0_HI: next_ptr0[15:8] = wr_data;
                core_regs_pkg::IDX_PTR1_LO: next_ptr1[7:0]  = wr_data;
                core_regs_pkg::IDX_PTR1_HI: next_ptr1[15:8] = wr_data;
                core_regs_pkg::IDX_BANK:    next_bank = wr_data[5:0];
                core_regs_pkg::IDX_WORK:    next_w = wr_data;
                core_regs_pkg::IDX_PC_LATCH: next_pc_latch = wr_data[6:0];
                default:                    next_w = w_value;
            endcase
        end
        sub_b = (alu_op == core_regs_pkg::ALU_SUB) ? ~alu_operand : alu_operand;
        sum   = {1'b0, w_value} + {1'b0, sub_b}
              + {8'h00, alu_op == core_regs_pkg::ALU_SUB};
        nib   = {1'b0, w_value[3:0]} + {1'b0, sub_b[3:0]}
              + {4'h0, alu_op == core_regs_pkg::ALU_SUB};
        case (alu_op)
            core_regs_pkg::ALU_ADD, core_regs_pkg::ALU_SUB: res = sum[7:0];
            core_regs_pkg::ALU_AND: res = w_value & alu_operand;
            core_regs_pkg::ALU_OR:  res = w_value | alu_operand;
            core_regs_pkg::ALU_XOR: res = w_value ^ alu_operand;
            core_regs_pkg::ALU_RLC: res = {alu_operand[6:0], status_value[core_regs_pkg::BIT_C]};
            core_regs_pkg::ALU_RRC: res = {status_value[core_regs_pkg::BIT_C], alu_operand[7:1]};
            default:                res = alu_operand;
        endcase
        if (alu_valid)
        begin
            next_alu_result = res;
            if (alu_to_w)
                next_w = res;
            if (alu_to_status)
                next_status[2:0] = res[2:0];
            case (alu_op)
                core_regs_pkg::ALU_ADD, core_regs_pkg::ALU_SUB:
                begin
                    next_status[core_regs_pkg::BIT_C]  = sum[8];
                    next_status[core_regs_pkg::BIT_DC] = nib[4];
                end
                core_regs_pkg::ALU_RLC: next_status[core_regs_pkg::BIT_C] = alu_operand[7];
                core_regs_pkg::ALU_RRC: next_status[core_regs_pkg::BIT_C] = alu_operand[0];
                default: next_status[core_regs_pkg::BIT_C] = next_status[core_regs_pkg::BIT_C];
            endcase
            if (alu_op != core_regs_pkg::ALU_RLC && alu_op != core_regs_pkg::ALU_RRC)
                next_status[core_regs_pkg::BIT_Z] = (res == 8'h00);
        end
        // clears first so that a same-cycle set wins
        // time-out and power-down flags
        if (watchdog_fired)
            next_status[core_regs_pkg::BIT_TO] = 1'b0;
        if (sleep_exec)
            next_status[core_regs_pkg::BIT_POWER_DOWN] = 1'b0;
        if (watchdog_clear || sleep_exec)
            next_status[core_regs_pkg::BIT_TO] = 1'b1;
        if (watchdog_clear)
            next_status[core_regs_pkg::BIT_POWER_DOWN] = 1'b1;
        next_status[7:5] = 3'h0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state        <= core_regs_pkg::ST_IDLE;
            ap_idx       <= 4'h0;
            ap_write     <= 1'b0;
            tk_flash     <= 1'b0;
            hreadyout    <= 1'b1;
            hrdata       <= 32'h0000_0000;
            hresp        <= 1'b0;
            dmem_addr    <= 13'h0000;
            dmem_rd      <= 1'b0;
            dmem_wr      <= 1'b0;
            dmem_wdata   <= 8'h00;
            flash_addr   <= 15'h0000;
            flash_rd     <= 1'b0;
            ptr0         <= 16'h0000;
            ptr1         <= 16'h0000;
            pc_value     <= 15'h0000;
            w_value      <= 8'h00;
            status_value <= core_regs_pkg::STATUS_RESET;
            bank_value   <= 6'h00;
            program_counter_high_latch <= 7'h00;
            alu_result   <= 8'h00;
        end
        else
        begin
            state        <= next_state;
            ap_idx       <= next_ap_idx;
            ap_write     <= next_ap_write;
            tk_flash     <= next_tk_flash;
            hreadyout    <= next_hreadyout;
            hrdata       <= next_hrdata;
            hresp        <= 1'b0;
            dmem_addr    <= next_dmem_addr;
            dmem_rd      <= next_dmem_rd;
            dmem_wr      <= next_dmem_wr;
            dmem_wdata   <= next_dmem_wdata;
            flash_addr   <= next_flash_addr;
            flash_rd     <= next_flash_rd;
            ptr0         <= next_ptr0;
            ptr1         <= next_ptr1;
            pc_value     <= next_pc;
            w_value      <= next_w;
            status_value <= next_status;
            bank_value   <= next_bank;
            program_counter_high_latch <= next_pc_latch;
            alu_result   <= next_alu_result;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_self_port_zero: assert property (
        state == core_regs_pkg::ST_ACCESS && is_port && tgt == core_regs_pkg::TGT_NONE
        |=> hrdata == 32'h0 && !dmem_wr && state == core_regs_pkg::ST_DONE)
        else $error("self-pointing port did not read zero");
    a_flash_write_drop: assert property (
        state == core_regs_pkg::ST_ACCESS && tgt == core_regs_pkg::TGT_FLASH && ap_write
        |=> !flash_rd && !dmem_wr && state == core_regs_pkg::ST_DONE)
        else $error("flash write was not dropped");
    a_flash_extra_cycle: assert property (
        state == core_regs_pkg::ST_ACCESS && tgt == core_regs_pkg::TGT_FLASH && !ap_write
        |=> flash_rd ##1 state == core_regs_pkg::ST_EXTRA ##2 hreadyout)
        else $error("flash read timing wrong");
    a_flash_low_byte: assert property (
        state == core_regs_pkg::ST_TAKE && tk_flash
        |=> hrdata == {24'h0, $past(flash_rdata[7:0])})
        else $error("flash read byte wrong");
    a_linear_step: assert property (
        state == core_regs_pkg::ST_ACCESS && is_port && ptr_sel == 16'h2050
        |=> dmem_addr == 13'h00A0 && dmem_rd != ap_write)
        else $error("linear address did not step banks");
    a_pcl_latch_load: assert property (
        wr_core && tgt_idx == core_regs_pkg::IDX_PC_LOW
        |=> pc_value == {$past(program_counter_high_latch), $past(hwdata[7:0])})
        else $error("low byte write did not load upper bits");
    a_timeout_clear: assert property (
        watchdog_fired && !watchdog_clear && !sleep_exec |=> !status_value[core_regs_pkg::BIT_TO])
        else $error("time-out flag not cleared");
    a_sleep_flags: assert property (
        sleep_exec && !watchdog_clear
        |=> !status_value[core_regs_pkg::BIT_POWER_DOWN] && status_value[core_regs_pkg::BIT_TO])
        else $error("sleep flags wrong");
    a_borrow_flag: assert property (
        alu_valid && alu_op == core_regs_pkg::ALU_SUB
        |=> status_value[core_regs_pkg::BIT_C] == ($past(w_value) >= $past(alu_operand)))
        else $error("borrow polarity wrong");
    a_zero_flag: assert property (
        alu_valid && alu_op == core_regs_pkg::ALU_AND
        |=> status_value[core_regs_pkg::BIT_Z] == (alu_result == 8'h00))
        else $error("zero flag wrong");

    c_data_read: cover property (state == core_regs_pkg::ST_TAKE && !tk_flash && !ap_write);
    c_flash_read: cover property (state == core_regs_pkg::ST_EXTRA);
    c_pcl_write: cover property (wr_core && tgt_idx == core_regs_pkg::IDX_PC_LOW);
endmodule
`default_nettype wire

// [design/core_regs_pkg.sv]
// constants, field layout and encodings for the core register group
// assumes a single hclk domain and word-wide AHB-Lite access
// Functional notes
// - accesses to either indirect port go to the address in its pointer
// - a pointer aimed at an indirect port reads 0 and drops writes
// - each pointer is 16 bits, written and read as two bytes
// - pointer 0x0000 to 0x1FFF maps straight onto absolute data addresses
// - pointer 0x2000 to 0x2FEF maps linearly onto the 80-byte RAM of banks 0 to 7
// - linear locations with no memory behind them read 0x00
// - linear addresses step from one bank's RAM block into the next
// - the 16 common bytes of each bank are outside the linear region
// - pointer top bit set selects flash with the low 15 bits
// - indirect flash reads return the low eight bits of the word
// - indirect writes to flash have no effect
// - indirect flash reads take one extra cycle
// - time-out flag set at power-up, watchdog clear, sleep; cleared on time-out
// - power-down flag set at power-up and watchdog clear; cleared by sleep
// - zero flag follows whether the result is zero, except on rotates through carry
// - digit carry is the carry out of result bit 3 on add or subtract
// - carry is the carry out of result bit 7 on add or subtract
// - subtract adds the two's complement, so carries act as inverted borrows
// - rotates through carry load carry with the bit shifted out
// - bank number holds six bits in 5:0
// - the latch holds seven upper program counter bits for later use
// - the low byte register reads and writes program counter bits 7:0
// - writing the low byte loads the upper bits from the latch
// - an ALU result sent to status cannot overwrite its own flags
package core_regs_pkg;
    localparam logic [3:0] IDX_PORT_ZERO = 4'h0;
    localparam logic [3:0] IDX_PORT_ONE  = 4'h1;
    localparam logic [3:0] IDX_PC_LOW    = 4'h2;
    localparam logic [3:0] IDX_STATUS    = 4'h3;
    localparam logic [3:0] IDX_PTR0_LO   = 4'h4;
    localparam logic [3:0] IDX_PTR0_HI   = 4'h5;
    localparam logic [3:0] IDX_PTR1_LO   = 4'h6;
    localparam logic [3:0] IDX_PTR1_HI   = 4'h7;
    localparam logic [3:0] IDX_BANK      = 4'h8;
    localparam logic [3:0] IDX_WORK      = 4'h9;
    localparam logic [3:0] IDX_PC_LATCH  = 4'hA;
    localparam int BIT_TO = 4;
    localparam int BIT_POWER_DOWN = 3;
    localparam int BIT_Z  = 2;
    localparam int BIT_DC = 1;
    localparam int BIT_C  = 0;
    localparam logic [7:0]  STATUS_RESET    = 8'h18;
    localparam logic [15:0] BANKED_LAST     = 16'h1FFF;
    localparam logic [15:0] LINEAR_BASE     = 16'h2000;
    localparam logic [15:0] LINEAR_LAST     = 16'h2FEF;
    localparam int          PTR_FLASH_BIT   = 15;
    localparam logic [11:0] RAM_BLOCK_BYTES = 12'h050;
    localparam logic [6:0]  RAM_BANK_START  = 7'h20;
    localparam logic [11:0] LINEAR_BANKS    = 12'h008;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_ACCESS = 6'h02,
        ST_REQ    = 6'h04,
        ST_EXTRA  = 6'h08,
        ST_TAKE   = 6'h10,
        ST_DONE   = 6'h20
    } bus_state_e;
    typedef enum logic [1:0] {
        TGT_NONE  = 2'h0,
        TGT_CORE  = 2'h1,
        TGT_DATA  = 2'h2,
        TGT_FLASH = 2'h3
    } target_e;
    typedef enum logic [2:0] {
        ALU_ADD  = 3'h0,
        ALU_SUB  = 3'h1,
        ALU_AND  = 3'h2,
        ALU_OR   = 3'h3,
        ALU_XOR  = 3'h4,
        ALU_RLC  = 3'h5,
        ALU_RRC  = 3'h6,
        ALU_MOVE = 3'h7
    } alu_op_e;
endpackage

// [tb/core_regs_memories.sv]
// data RAM and program flash models behind the core register group
// assumes registered reads: data one cycle after a read pulse, flash held two cycles
`timescale 1ns/100ps
`default_nettype none
module core_regs_memories
(
    input  wire logic        hclk,
    input  wire logic [12:0] dmem_addr,
    input  wire logic        dmem_rd,
    input  wire logic        dmem_wr,
    input  wire logic [7:0]  dmem_wdata,
    output var logic [7:0]   dmem_rdata,
    input  wire logic [14:0] flash_addr,
    input  wire logic        flash_rd,
    output var logic [13:0]  flash_rdata
);
    logic [7:0] ram [0:8191];
    logic [1:0] hold = 2'h0;
    initial {dmem_rdata, flash_rdata} = 22'h0;
    // outside a read the lines toggle, so stale data never passes for a match
    always @(posedge hclk)
    begin
        dmem_rdata <= dmem_rd ? ram[dmem_addr] : ~dmem_rdata;
        if (dmem_wr)
            ram[dmem_addr] <= dmem_wdata;
        hold <= flash_rd ? 2'h2 : hold - {1'b0, hold != 2'h0};
        flash_rdata <= flash_rd ? {6'h3F, flash_addr[7:0] ^ 8'h5A}
                     : (hold > 2'h1 ? flash_rdata : ~flash_rdata);
    end
endmodule
`default_nettype wire

// [tb/core_regs_test.sv]
// self-checking bench for the core register group
// assumes the memory models of core_regs_memories on the far side
`timescale 1ns/100ps
`default_nettype none
module core_regs_test;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        alu_valid = 1'b0, alu_to_w = 1'b0, alu_to_status = 1'b0, pc_step = 1'b0;
    logic        watchdog_clear = 1'b0, sleep_exec = 1'b0, watchdog_fired = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, alu_op = 3'h0;
    logic [7:0]  alu_operand = 8'h00, dmem_wdata, dmem_rdata, alu_result, w_value, status_value;
    logic        hreadyout, hresp, dmem_rd, dmem_wr, flash_rd;
    logic [12:0] dmem_addr;
    logic [14:0] flash_addr, pc_value;
    logic [13:0] flash_rdata;
    logic [5:0]  bank_value;
    logic [6:0]  program_counter_high_latch;
    int          nw, nd, bad_count = 0, total_checks = 0;
    always #2 hclk = ~hclk;
    core_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dmem_addr(dmem_addr),
        .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
        .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_rdata(flash_rdata),
        .alu_valid(alu_valid), .alu_op(alu_op), .alu_operand(alu_operand), .alu_to_w(alu_to_w),
        .alu_to_status(alu_to_status), .pc_step(pc_step), .watchdog_clear(watchdog_clear),
        .sleep_exec(sleep_exec), .watchdog_fired(watchdog_fired), .alu_result(alu_result),
        .pc_value(pc_value), .w_value(w_value), .status_value(status_value),
        .bank_value(bank_value), .program_counter_high_latch(program_counter_high_latch));
    core_regs_memories mem (.hclk(hclk), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
        .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
        .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_rdata(flash_rdata));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // single word transfer; w counts data-phase edges up to hready
    task xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output int w);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= core_regs_pkg::HTRANS_NONSEQ;
        haddr <= {26'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, wd};
        w = 0;
        do
        begin
            @(posedge hclk);
            w++;
        end
        while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task setp(input logic [3:0] lo, input logic [15:0] v);
        xfer(1'b1, lo, v[7:0], nw);
        xfer(1'b1, lo + 4'h1, v[15:8], nw);
    endtask
    // v is {pc_step, watchdog clear, sleep, watchdog fired}, or an alu op when op_n is low
    task evt(input logic [3:0] v, input logic op_n, input logic [7:0] opd);
        @(posedge hclk);
        {pc_step, watchdog_clear, sleep_exec, watchdog_fired} <= op_n ? v : 4'h0;
        {alu_valid, alu_to_w, alu_op, alu_operand} <= {!op_n, 1'b1, v[2:0], opd};
        @(posedge hclk);
        {pc_step, watchdog_clear, sleep_exec, watchdog_fired, alu_valid} <= 5'h00;
        @(posedge hclk);
    endtask
    task t_regs;
        xfer(1'b0, 4'h3, 8'h00, nw);
        chk(rv, 32'h18);
        xfer(1'b1, 4'h8, 8'hFF, nw);
        xfer(1'b0, 4'h8, 8'h00, nw);
        chk(rv, 32'h3F);
        xfer(1'b1, 4'hA, 8'hFF, nw);
        xfer(1'b0, 4'hA, 8'h00, nw);
        chk(rv, 32'h7F);
        xfer(1'b1, 4'hA, 8'h12, nw);
        chk(pc_value, 32'h0);
        chk({hresp, bank_value, program_counter_high_latch}, 32'h1F92);
        xfer(1'b1, 4'h2, 8'h34, nw);
        chk(pc_value, 32'h1234);
        evt(4'h8, 1'b1, 8'h00);
        xfer(1'b0, 4'h2, 8'h00, nw);
        chk(rv, 32'h35);
        $display("register test ended");
    endtask
    task t_ports;
        setp(4'h4, 16'h204F);
        xfer(1'b1, 4'h0, 8'h3C, nw);
        setp(4'h4, 16'h2050);
        xfer(1'b1, 4'h0, 8'hA5, nw);
        setp(4'h6, 16'h006F);
        xfer(1'b0, 4'h1, 8'h00, nw);
        chk(rv, 32'h3C);
        setp(4'h6, 16'h00A0);
        xfer(1'b0, 4'h1, 8'h00, nd);
        chk(rv, 32'hA5);
        xfer(1'b0, 4'h5, 8'h00, nw);
        chk(rv, 32'h20);
        setp(4'h4, 16'h0001);
        xfer(1'b0, 4'h0, 8'h00, nw);
        chk(rv, 32'h0);
        setp(4'h4, 16'h2280);
        xfer(1'b0, 4'h0, 8'h00, nw);
        chk(rv, 32'h0);
        setp(4'h6, 16'h8123);
        xfer(1'b1, 4'h1, 8'h77, nw);
        xfer(1'b0, 4'h1, 8'h00, nw);
        chk(rv, 32'h79);
        chk(nw, nd + 1);
        $display("indirect test ended");
    endtask
    task t_alu;
        xfer(1'b1, 4'h9, 8'h0F, nw);
        evt(4'h0, 1'b0, 8'h01);
        chk({w_value, status_value}, 32'h101A);
        evt(4'h1, 1'b0, 8'h10);
        chk({w_value, status_value}, 32'h001F);
        evt(4'h5, 1'b0, 8'h00);
        chk({w_value, status_value}, 32'h011E);
        evt(4'h2, 1'b1, 8'h00);
        chk(status_value, 32'h16);
        evt(4'h1, 1'b1, 8'h00);
        chk(status_value, 32'h06);
        evt(4'h4, 1'b1, 8'h00);
        chk(status_value, 32'h1E);
        evt(4'h6, 1'b0, 8'h03);
        chk({w_value, status_value}, 32'h011F);
        evt(4'h4, 1'b0, 8'hF0);
        chk({w_value, status_value}, 32'hF11B);
        evt(4'h2, 1'b0, 8'h0E);
        chk({w_value, status_value}, 32'h001F);
        evt(4'h3, 1'b0, 8'h80);
        chk({w_value, status_value}, 32'h801B);
        alu_to_status <= 1'b1;
        evt(4'h0, 1'b0, 8'h85);
        chk({alu_result, w_value, status_value}, 32'h050519);
        evt(4'h7, 1'b0, 8'h00);
        chk({w_value, status_value}, 32'h001C);
        alu_to_status <= 1'b0;
        $display("alu and power test ended");
    endtask
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_ports;
        t_alu;
        complete_run;
    end
    // the tests need about 1 us; twenty times that means a hang
    initial
    begin
        #20000;
        bad_count++;
        complete_run;
    end
endmodule
`default_nettype wire
